/* bench/itf_host_model.sv */
// Host processor model that issues APB transfers.
`timescale 1ns/1ns

module itf_host_model (
  input  wire logic        pclk,    // Clock.
  output logic             psel,    // Select.
  output logic             penable, // Access.
  output logic             pwrite,  // Write.
  output logic [11:0]      paddr,   // Address.
  output logic [31:0]      pwdata,  // Write data.
  input  wire logic [31:0] prdata,  // Read data.
  input  wire logic        pready,  // Ready.
  input  wire logic        pslverr  // Error.
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // Released address and data are inverted so stale values cannot pass.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~{24'h00_0000, d};
  endtask
endmodule // itf_host_model

/* bench/itf_top_chk.sv */
// Port assertions for the interval timer and interrupt flag block.
`timescale 1ns/1ns
`include "itf_regs.svh"

module itf_top_chk (
  input wire logic                    pclk,                // Clock.
  input wire logic                    presetn,             // Reset, low.
  input wire logic                    psel,                // Select.
  input wire logic                    penable,             // Access.
  input wire logic                    pwrite,              // Write.
  input wire logic [`ITF_ADDR_W-1:0]  paddr,               // Address.
  input wire logic [31:0]             pwdata,              // Write data.
  input wire logic [31:0]             prdata,              // Read data.
  input wire logic                    pready,              // Ready.
  input wire logic                    pslverr,             // Error.
  input wire logic [`ITF_NUM_EXT-1:0] event_in,            // Sources.
  input wire logic                    port_b_bit_seven_o,  // Pin.
  input wire logic                    port_b_bit_seven_oe, // Pin enable.
  input wire logic                    irq_n,               // Request, low.
  input wire logic                    irq                  // Request, high.
);
  wire logic wr_acc;
  wire logic rd_acc;
  assign wr_acc = psel && penable && pready && pwrite;
  assign rd_acc = psel && penable && pready && !pwrite;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_req_pair;
    irq == !irq_n;
  endproperty
  a_req_pair: assert property (p_req_pair) else $error("request outputs disagree");
  property p_any_bit;
    rd_acc && paddr == `ITF_OFF_FLAG |-> prdata[7] == !$past(irq_n);
  endproperty
  a_any_bit: assert property (p_any_bit) else $error("flag bit 7 wrong");
  property p_en_read;
    rd_acc && paddr == `ITF_OFF_ENABLE |-> prdata[7];
  endproperty
  a_en_read: assert property (p_en_read) else $error("enable bit 7 not one");
  property p_en_clr_all;
    wr_acc && paddr == `ITF_OFF_ENABLE && pwdata[7:0] == 8'h7f |=> irq_n [*2];
  endproperty
  a_en_clr_all: assert property (p_en_clr_all) else $error("request after disable");
  property p_oe_follow;
    wr_acc && paddr == `ITF_OFF_AUX_CTRL |=> port_b_bit_seven_oe == $past(pwdata[7]);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("pin enable not written");
  property p_oe_hold;
    !$stable(port_b_bit_seven_oe) |-> $past(wr_acc && paddr == `ITF_OFF_AUX_CTRL);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("pin enable changed alone");
  property p_start_pin;
    wr_acc && paddr == `ITF_OFF_CNT_HI |=> !port_b_bit_seven_o;
  endproperty
  a_start_pin: assert property (p_start_pin) else $error("pin not low on start");
  property p_pulse;
    wr_acc && paddr == `ITF_OFF_CNT_HI && pwdata[7:0] != 8'h00 |=> !port_b_bit_seven_o [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse ended early");
endmodule // itf_top_chk

/* bench/test_interval_timer_irq_flags.sv */
// Self-checking testbench for the interval timer and interrupt flag block.
`timescale 1ns/1ns
`include "itf_regs.svh"

module test_interval_timer_irq_flags;
  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [`ITF_ADDR_W-1:0] paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic [5:0]             event_in;
  logic                   pin_o;
  logic                   pin_oe;
  logic                   irq_n;
  logic                   irq;
  int                     n_mismatch;
  int                     checks;
  time                    tq[$];
  time                    t0;

  itf_top i_itf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_in(event_in), .port_b_bit_seven_o(pin_o),
    .port_b_bit_seven_oe(pin_oe), .irq_n(irq_n), .irq(irq));
  itf_host_model i_itf_host_model (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  always @(pin_o) tq.push_back($time);

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    i_itf_host_model.xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e, input string nm);
    logic [31:0] rd;
    logic        err;
    i_itf_host_model.xfer(1'b0, a, 8'h00, rd, err);
    chk(nm, {24'h00_0000, e}, rd);
  endtask
  task automatic start(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] aux);
    wr(`ITF_OFF_CNT_LO, lo);
    wr(`ITF_OFF_AUX_CTRL, aux);
    wr(`ITF_OFF_CNT_HI, hi);
    t0 = $time;
    tq.delete();
  endtask
  task automatic wait_tog(input int k);
    int n;
    n = 0;
    while (tq.size() < k && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk("toggles", 32'(k), 32'(tq.size()));
  endtask
  task automatic results;
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    n_mismatch++;
    results();
  end

  initial begin
    logic [7:0]  en, v, ev, c, lo, hi;
    logic [31:0] rd;
    logic        err;
    void'($urandom(32'hde1eec75));
    presetn = 1'b0;
    event_in = 6'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`ITF_OFF_ENABLE, 8'h80, "enable_rst");
    rdc(`ITF_OFF_FLAG, 8'h00, "flag_rst");
    rdc(`ITF_OFF_LATCH_HI, 8'hff, "latch_hi_rst");
    i_itf_host_model.xfer(1'b0, 12'h020, 8'h00, rd, err);
    chk("unmapped", 32'h0000_0001, {rd[30:0], err});
    en = 8'h00;
    repeat (6) begin
      v = 8'($urandom);
      en = v[7] ? (en | {1'b0, v[6:0]}) : (en & ~{1'b0, v[6:0]});
      wr(`ITF_OFF_ENABLE, v);
      rdc(`ITF_OFF_ENABLE, en | 8'h80, "enable");
    end
    wr(`ITF_OFF_ENABLE, 8'h7f);
    wr(`ITF_OFF_EDGE_SEL, 8'h3f);
    ev = 8'($urandom_range(1, 63));
    event_in <= ev[5:0];
    repeat (5) @(posedge pclk);
    rdc(`ITF_OFF_FLAG, ev, "flag_masked");
    chk("irq_n_masked", 32'h0000_0001, 32'(irq_n));
    wr(`ITF_OFF_ENABLE, ev | 8'h80);
    rdc(`ITF_OFF_FLAG, ev | 8'h80, "flag_any");
    chk("irq_n", 32'h0000_0000, 32'(irq_n));
    c = 8'($urandom_range(0, 63));
    wr(`ITF_OFF_FLAG, c);
    v = ev & ~c;
    rdc(`ITF_OFF_FLAG, v | {|v, 7'h00}, "flag_clear");
    wr(`ITF_OFF_EDGE_SEL, 8'h00);
    event_in <= 6'h00;
    repeat (5) @(posedge pclk);
    rdc(`ITF_OFF_FLAG, ev | 8'h80, "flag_fall");
    i_itf_host_model.xfer(1'b0, `ITF_OFF_FLAG, 8'h00, rd, err);
    wr(`ITF_OFF_FLAG, rd[7:0]);
    rdc(`ITF_OFF_FLAG, 8'h00, "flag_copy_clear");
    wr(`ITF_OFF_ENABLE, 8'hc0);
    for (int i = 0; i < 3; i++) begin
      hi = (i == 0) ? 8'h01 : 8'h00;
      lo = 8'($urandom_range(2, 60));
      start(hi, lo, 8'h80);
      rdc(`ITF_OFF_FLAG, 8'h00, "flag_start");
      rdc(`ITF_OFF_LATCH_HI, hi, "latch_hi_copy");
      wait_tog(2);
      chk("pin_low", 32'(t0), 32'(tq[0]));
      chk("pin_width", 32'(({hi, lo} + 16'h0001) * 20), 32'(tq[1] - t0));
      repeat (40) @(posedge pclk);
      chk("pin_single", 32'h0000_0002, 32'(tq.size()));
      rdc(`ITF_OFF_FLAG, 8'hc0, "flag_timeout");
    end
    start(8'h00, 8'h14, 8'hc0);
    wr(`ITF_OFF_LATCH_LO, 8'h09);
    wait_tog(4);
    chk("free_first", 32'h0000_01a4, 32'(tq[1] - t0));
    chk("free_second", 32'h0000_00c8, 32'(tq[2] - tq[1]));
    chk("free_third", 32'h0000_00c8, 32'(tq[3] - tq[2]));
    rdc(`ITF_OFF_FLAG, 8'hc0, "flag_free_run");
    chk("pin_oe", 32'h0000_0001, 32'(pin_oe));
    results();
  end
endmodule // test_interval_timer_irq_flags

bind itf_top itf_top_chk i_itf_top_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .event_in(event_in),
  .port_b_bit_seven_o(port_b_bit_seven_o), .port_b_bit_seven_oe(port_b_bit_seven_oe),
  .irq_n(irq_n), .irq(irq));

/* src/itf_irq.sv */
// Interrupt flag and enable registers with the merged request.
`timescale 1ns/1ns
`include "itf_regs.svh"

module itf_irq (
  input  wire logic               pclk,       // Bus clock.
  input  wire logic               presetn,    // Asynchronous reset, active low.
  input  wire itf_pkg::itf_src_t  set_evt,    // One-cycle events per source.
  input  wire itf_pkg::itf_src_t  hw_clr,     // Side-effect clears per source.
  input  wire logic               flag_we,    // Write pulse for the flag register.
  input  wire logic               enable_we,  // Write pulse for the enable register.
  input  wire itf_pkg::itf_byte_t wdata,      // Byte written.
  output itf_pkg::itf_src_t       flags,      // Sticky flags.
  output itf_pkg::itf_src_t       enables,    // Enable bits.
  output logic                    irq_any     // Any enabled flag set.
);

  itf_pkg::itf_src_t sw_clr;
  itf_pkg::itf_src_t next_flags;

  function automatic itf_pkg::itf_src_t enable_update(
    input itf_pkg::itf_src_t  cur,
    input itf_pkg::itf_byte_t wr
  );
    if (wr[`ITF_BIT_SET_CLR]) begin
      enable_update = cur | wr[6:0];
    end else begin
      enable_update = cur & ~wr[6:0];
    end
  endfunction

  // Zero bits leave flags alone; an event in the clear cycle still lands.
  assign sw_clr     = flag_we ? wdata[6:0] : `ITF_RST_FLAGS;
  assign next_flags = (flags & ~(sw_clr | hw_clr)) | set_evt;
  assign irq_any    = |(flags & enables);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= `ITF_RST_FLAGS;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enables <= `ITF_RST_ENABLES;
    end else if (enable_we) begin
      enables <= enable_update(enables, wdata);
    end
  end

endmodule // itf_irq

/* src/itf_pkg.sv */
// Types shared by the interval timer and interrupt flag block.
package itf_pkg;

  typedef logic [7:0]  itf_byte_t;
  typedef logic [15:0] itf_word_t;
  typedef logic [6:0]  itf_src_t;

  typedef enum logic {
    ITF_TMR_IDLE,
    ITF_TMR_RUN
  } itf_tmr_e;

endpackage

/* src/itf_regs.svh */
// Register offsets, field positions, reset values and widths for the interval timer block.
`ifndef ITF_REGS_SVH
`define ITF_REGS_SVH

`define ITF_ADDR_W          12
`define ITF_OFF_CNT_LO      12'h000
`define ITF_OFF_CNT_HI      12'h004
`define ITF_OFF_LATCH_LO    12'h008
`define ITF_OFF_LATCH_HI    12'h00c
`define ITF_OFF_AUX_CTRL    12'h010
`define ITF_OFF_FLAG        12'h014
`define ITF_OFF_ENABLE      12'h018
`define ITF_OFF_EDGE_SEL    12'h01c

`define ITF_NUM_SRC         7
`define ITF_NUM_EXT         6
`define ITF_SRC_TIMER       6
`define ITF_BIT_ANY         7
`define ITF_BIT_SET_CLR     7
`define ITF_BIT_PIN_EN      7
`define ITF_BIT_FREE_RUN    6

`define ITF_RST_LATCH       16'hffff
`define ITF_RST_COUNT       16'hffff
`define ITF_RST_AUX_CTRL    8'h00
`define ITF_RST_FLAGS       7'h00
`define ITF_RST_ENABLES     7'h00
`define ITF_RST_EDGE_SEL    6'h00
`define ITF_RST_PIN         1'b1

`endif

/* src/itf_timer.sv */
// Sixteen-bit down counter with reload latches, one-shot and free-running modes and pin drive.
`timescale 1ns/1ns
`include "itf_regs.svh"

module itf_timer (
  input  wire logic              pclk,        // Bus clock.
  input  wire logic              presetn,     // Asynchronous reset, active low.
  input  wire logic              free_run,    // High selects free-running mode.
  input  wire logic              latch_lo_we, // Write pulse for the low latch byte.
  input  wire logic              latch_hi_we, // Write pulse for the high latch byte.
  input  wire logic              cnt_hi_we,   // Write pulse for the counter high byte.
  input  wire itf_pkg::itf_byte_t wdata,      // Byte written.
  output itf_pkg::itf_word_t     latch,       // Reload latch value.
  output itf_pkg::itf_word_t     count,       // Current counter value.
  output logic                   timeout_evt, // One-cycle time-out event.
  output logic                   pin_level    // Level for the port pin.
);

  itf_pkg::itf_tmr_e  state;
  itf_pkg::itf_tmr_e  next_state;
  itf_pkg::itf_word_t next_count;
  logic               at_zero;
  logic               pin_toggle;

  assign at_zero     = (count == 16'h0000);
  assign timeout_evt = at_zero && (state == itf_pkg::ITF_TMR_RUN) && !cnt_hi_we;
  assign pin_toggle  = timeout_evt && (free_run || !pin_level);

  // The counter keeps decrementing after a one-shot time-out, but only a new start re-arms it.
  always_comb begin
    next_state = state;
    next_count = count - 16'h0001;
    if (cnt_hi_we) begin
      next_state = itf_pkg::ITF_TMR_RUN;
      next_count = {wdata, latch[7:0]};
    end else if (timeout_evt) begin
      if (free_run) begin
        next_count = latch;
      end else begin
        next_state = itf_pkg::ITF_TMR_IDLE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= itf_pkg::ITF_TMR_IDLE;
      count <= `ITF_RST_COUNT;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // Latch writes touch only the latch, never the running count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch <= `ITF_RST_LATCH;
    end else begin
      if (latch_lo_we) begin
        latch[7:0] <= wdata;
      end
      if (latch_hi_we || cnt_hi_we) begin
        latch[15:8] <= wdata;
      end
    end
  end

  // Pin goes low on start; one-shot returns it high at time-out, free-run toggles it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level <= `ITF_RST_PIN;
    end else if (cnt_hi_we) begin
      pin_level <= 1'b0;
    end else if (pin_toggle) begin
      pin_level <= !pin_level;
    end
  end

endmodule // itf_timer

/* src/itf_top.sv */
// APB slave top of the interval timer with interrupt flag and enable logic.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "itf_regs.svh"

module itf_top (
  input  wire logic                     pclk,                // Bus clock, 50 MHz.
  input  wire logic                     presetn,             // Asynchronous reset, active low.
  input  wire logic                     psel,                // APB select.
  input  wire logic                     penable,             // APB access phase.
  input  wire logic                     pwrite,              // APB write when high.
  input  wire logic [`ITF_ADDR_W-1:0]   paddr,               // APB byte address.
  input  wire logic [31:0]              pwdata,              // APB write data.
  output logic [31:0]                   prdata,              // APB read data.
  output logic                          pready,              // APB ready.
  output logic                          pslverr,             // APB error on unmapped address.
  input  wire logic [`ITF_NUM_EXT-1:0]  event_in,            // Edge-detecting source pins.
  output logic                          port_b_bit_seven_o,  // Timer pin level.
  output logic                          port_b_bit_seven_oe, // Timer pin drive enable.
  output logic                          irq_n,               // Interrupt request, active low.
  output logic                          irq                  // Interrupt request, active high.
);

  // Bus phase decode.
  wire logic setup_ph;
  wire logic access_ph;
  wire logic wr_acc;
  wire logic rd_acc;

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_acc    = access_ph && pwrite;
  assign rd_acc    = access_ph && !pwrite;

  // Address decode.
  wire logic hit_cnt_lo;
  wire logic hit_cnt_hi;
  wire logic hit_latch_lo;
  wire logic hit_latch_hi;
  wire logic hit_aux;
  wire logic hit_flag;
  wire logic hit_enable;
  wire logic hit_edge;
  wire logic hit_any;

  // Full-word compare, so unaligned or out-of-map addresses hit nothing.
  function automatic logic addr_hit(
    input logic [`ITF_ADDR_W-1:0] addr,
    input logic [`ITF_ADDR_W-1:0] offset
  );
    addr_hit = (addr == offset);
  endfunction

  assign hit_cnt_lo   = addr_hit(paddr, `ITF_OFF_CNT_LO);
  assign hit_cnt_hi   = addr_hit(paddr, `ITF_OFF_CNT_HI);
  assign hit_latch_lo = addr_hit(paddr, `ITF_OFF_LATCH_LO);
  assign hit_latch_hi = addr_hit(paddr, `ITF_OFF_LATCH_HI);
  assign hit_aux      = addr_hit(paddr, `ITF_OFF_AUX_CTRL);
  assign hit_flag     = addr_hit(paddr, `ITF_OFF_FLAG);
  assign hit_enable   = addr_hit(paddr, `ITF_OFF_ENABLE);
  assign hit_edge     = addr_hit(paddr, `ITF_OFF_EDGE_SEL);
  assign hit_any      = hit_cnt_lo || hit_cnt_hi || hit_latch_lo || hit_latch_hi
                     || hit_aux || hit_flag || hit_enable || hit_edge;

  // Write strobes, one cycle each, at the access edge.
  wire logic               we_latch_lo;
  wire logic               we_latch_hi;
  wire logic               we_cnt_hi;
  wire logic               we_aux;
  wire logic               we_flag;
  wire logic               we_enable;
  wire logic               we_edge;
  wire itf_pkg::itf_byte_t wbyte;

  assign wbyte       = pwdata[7:0];
  // A counter low write lands in the low latch, ready for the start write.
  assign we_latch_lo = wr_acc && (hit_cnt_lo || hit_latch_lo);
  assign we_latch_hi = wr_acc && hit_latch_hi;
  assign we_cnt_hi   = wr_acc && hit_cnt_hi;
  assign we_aux      = wr_acc && hit_aux;
  assign we_flag     = wr_acc && hit_flag;
  assign we_enable   = wr_acc && hit_enable;
  assign we_edge     = wr_acc && hit_edge;

  // Control registers.
  itf_pkg::itf_byte_t           aux_ctrl;
  logic [`ITF_NUM_EXT-1:0]      edge_sel;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_ctrl <= `ITF_RST_AUX_CTRL;
    end else if (we_aux) begin
      aux_ctrl <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_sel <= `ITF_RST_EDGE_SEL;
    end else if (we_edge) begin
      edge_sel <= wbyte[`ITF_NUM_EXT-1:0];
    end
  end

  wire logic pin_enable;
  wire logic free_run;

  assign pin_enable = aux_ctrl[`ITF_BIT_PIN_EN];
  assign free_run   = aux_ctrl[`ITF_BIT_FREE_RUN];

  // Edge sources: two flip-flops of synchronisation, then a history stage for the edge.
  logic [`ITF_NUM_EXT-1:0] ev_meta;
  logic [`ITF_NUM_EXT-1:0] ev_sync;
  logic [`ITF_NUM_EXT-1:0] ev_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_meta <= `ITF_RST_EDGE_SEL;
      ev_sync <= `ITF_RST_EDGE_SEL;
      ev_prev <= `ITF_RST_EDGE_SEL;
    end else begin
      ev_meta <= event_in;
      ev_sync <= ev_meta;
      ev_prev <= ev_sync;
    end
  end

  // A set edge_sel bit picks the rising edge, a clear bit the falling edge.
  wire logic [`ITF_NUM_EXT-1:0] ev_rise;
  wire logic [`ITF_NUM_EXT-1:0] ev_fall;
  wire logic [`ITF_NUM_EXT-1:0] ev_hit;

  assign ev_rise = ev_sync & ~ev_prev;
  assign ev_fall = ~ev_sync & ev_prev;
  assign ev_hit  = (edge_sel & ev_rise) | (~edge_sel & ev_fall);

  // Timer.
  itf_pkg::itf_word_t latch;
  itf_pkg::itf_word_t count;
  logic               timeout_evt;
  logic               pin_level;

  itf_timer i_itf_timer (
    .pclk        (pclk),
    .presetn     (presetn),
    .free_run    (free_run),
    .latch_lo_we (we_latch_lo),
    .latch_hi_we (we_latch_hi),
    .cnt_hi_we   (we_cnt_hi),
    .wdata       (wbyte),
    .latch       (latch),
    .count       (count),
    .timeout_evt (timeout_evt),
    .pin_level   (pin_level)
  );

  // Interrupt flags. Reading the counter low byte acknowledges the timer as well.
  wire itf_pkg::itf_src_t set_evt;
  wire itf_pkg::itf_src_t hw_clr;
  wire logic              timer_clr;
  itf_pkg::itf_src_t      flags;
  itf_pkg::itf_src_t      enables;
  logic                   irq_any;

  assign timer_clr = we_cnt_hi || (rd_acc && hit_cnt_lo);
  assign set_evt   = {timeout_evt, ev_hit};
  assign hw_clr    = {timer_clr, `ITF_RST_EDGE_SEL};

  itf_irq i_itf_irq (
    .pclk      (pclk),
    .presetn   (presetn),
    .set_evt   (set_evt),
    .hw_clr    (hw_clr),
    .flag_we   (we_flag),
    .enable_we (we_enable),
    .wdata     (wbyte),
    .flags     (flags),
    .enables   (enables),
    .irq_any   (irq_any)
  );

  assign irq_n = !irq_any;
  assign irq   = irq_any;

  // Pin drive: the output enable follows the control bit; the level comes from the timer.
  assign port_b_bit_seven_oe = pin_enable;
  assign port_b_bit_seven_o  = pin_level;

  // Read data is captured in the setup cycle and presented in the access cycle.
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    case (1'b1)
      hit_cnt_lo:   rd_byte = count[7:0];
      hit_cnt_hi:   rd_byte = count[15:8];
      hit_latch_lo: rd_byte = latch[7:0];
      hit_latch_hi: rd_byte = latch[15:8];
      hit_aux:      rd_byte = aux_ctrl;
      hit_flag:     rd_byte = {irq_any, flags};
      hit_enable:   rd_byte = {1'b1, enables};
      hit_edge:     rd_byte = {2'b00, edge_sel};
      default:      rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata  <= {24'h00_0000, pwrite ? 8'h00 : rd_byte};
      pslverr <= !hit_any;
    end else if (!psel) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // No wait states: the slave is ready in every access cycle.
  assign pready = access_ph;

endmodule // itf_top
